// [shared/bfr_consts.vh]
// Purpose: constants for the frame check sequence relay block
// Assumes: octet-wide frame streams, check sequence in last four octets
// Notes: definitions only
`ifndef BFR_CONSTS_VH
`define BFR_CONSTS_VH
`define BFR_POLY_REFL 32'hedb88320
`define BFR_CRC_INIT 32'hffffffff
`define BFR_CRC_XOR 32'hffffffff
`define BFR_CRC_RESIDUE 32'hdebb20e3
`define BFR_FCS_OCTETS 3'd4
`define BFR_ST_IDLE 2'd0
`define BFR_ST_BODY 2'd1
`define BFR_ST_TAIL 2'd2
`define BFR_ST_END 2'd3
`endif

// [hdl/bfr_crc_step.v]
// Purpose: one octet step of the 32-bit frame check remainder
// Assumes: octet bits fed least significant first, reflected register
// Notes: pure combinational
`timescale 1ns/10ps
`include "bfr_consts.vh"
module bfr_crc_step (
  input wire [31:0] crc_in, // Running remainder
  input wire [7:0] data_in, // Next octet
  output wire [31:0] crc_out // Updated remainder
);
  function [31:0] step8;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ `BFR_POLY_REFL;
        else
          r = r >> 1;
      end
      step8 = r;
    end
  endfunction
  assign crc_out = step8(crc_in, data_in);
endmodule // bfr_crc_step

// [hdl/bfr_crc_acc.v]
// Purpose: running check accumulator with clear and advance
// Assumes: clear and advance never matter together except clear first
// Notes: preset of all ones inverts the leading 32 bits
`timescale 1ns/10ps
`include "bfr_consts.vh"
module bfr_crc_acc (
  input wire clock, // System clock
  input wire rst_n, // Async reset, active low
  input wire clear, // Start new frame
  input wire advance, // Take one octet
  input wire [7:0] data, // Octet
  output wire [31:0] crc, // Current remainder
  output wire [31:0] next_crc // Remainder including this octet
);
  reg [31:0] crc_q;
  wire [31:0] base;
  assign base = clear ? `BFR_CRC_INIT : crc_q;
  bfr_crc_step u_step (
    .crc_in(base),
    .data_in(data),
    .crc_out(next_crc)
  );
  assign crc = crc_q;
  // Accumulator register
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      crc_q <= 32'hffffffff;
    else if (advance)
      crc_q <= next_crc;
    else if (clear)
      crc_q <= `BFR_CRC_INIT;
  end
endmodule // bfr_crc_acc

// [hdl/bfr_fcs_relay.v]
// Purpose: check received frames and relay them with a kept or fresh check
// Assumes: octet stream in, frame includes its four check octets, one clock
// Notes: payload octets stream through with four octets of delay
`timescale 1ns/10ps
`include "bfr_consts.vh"
module bfr_fcs_relay (
  input wire clock, // System clock, 40 MHz
  input wire rst_n, // Async reset, active low
  input wire rx_valid, // Received octet valid
  input wire [7:0] rx_data, // Received octet
  input wire rx_last, // Last octet of received frame
  output wire rx_ready, // Block takes octets
  input wire orig_valid, // Original stored octet valid, for re-check
  input wire [7:0] orig_data, // Original stored octet as received
  input wire orig_last, // Last original octet
  input wire regen, // Fresh check wanted (media differ or data changed)
  output reg tx_valid, // Outgoing octet valid
  output reg [7:0] tx_data, // Outgoing octet
  output reg tx_last, // Last outgoing octet
  input wire tx_ready, // Transmit side takes octet
  output reg frame_done, // Frame finished pulse
  output reg frame_good, // Frame passed checks, with frame_done
  output reg frame_drop // Frame must be discarded, with frame_done
);
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] dly_q;
  reg [2:0] fill_q;
  reg [2:0] tail_q;
  reg [31:0] fcs_q;
  reg regen_q;
  reg rx_bad_q;
  reg orig_bad_q;
  reg orig_done_q;
  wire take;
  wire [31:0] rx_crc;
  wire [31:0] rx_next;
  wire [31:0] gen_crc;
  wire [31:0] gen_next;
  wire [31:0] chk_next;
  wire rx_start;
  wire orig_start;
  wire gen_adv;
  wire [7:0] out_octet;
  reg orig_first_q;
  reg rx_first_q;

  // Input accepted in idle or body state when output is free
  assign rx_ready = (state_q == `BFR_ST_IDLE || state_q == `BFR_ST_BODY) &&
                    (!tx_valid || tx_ready);
  assign take = rx_valid && rx_ready;
  assign rx_start = take && rx_first_q;
  assign out_octet = dly_q[7:0];
  // Octet leaving the delay line is payload once four are held
  // A full delay line left over from the last frame holds no payload
  assign gen_adv = take && !rx_start && (fill_q == `BFR_FCS_OCTETS);

  bfr_crc_acc u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .clear(rx_start),
    .advance(take),
    .data(rx_data),
    .crc(rx_crc),
    .next_crc(rx_next)
  );

  bfr_crc_acc u_gen (
    .clock(clock),
    .rst_n(rst_n),
    .clear(rx_start),
    .advance(gen_adv),
    .data(out_octet),
    .crc(gen_crc),
    .next_crc(gen_next)
  );

  assign orig_start = orig_valid && orig_first_q;
  bfr_crc_acc u_chk (
    .clock(clock),
    .rst_n(rst_n),
    .clear(orig_start),
    .advance(orig_valid),
    .data(orig_data),
    .crc(),
    .next_crc(chk_next)
  );

  // Frame start tracking
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_first_q <= 1'b1;
      orig_first_q <= 1'b1;
    end else begin
      if (take)
        rx_first_q <= rx_last;
      if (orig_valid)
        orig_first_q <= orig_last;
    end
  end

  // Next state
  always @* begin
    state_d = state_q;
    case (state_q)
      `BFR_ST_IDLE: begin
        if (take)
          state_d = rx_last ? `BFR_ST_TAIL : `BFR_ST_BODY;
      end
      `BFR_ST_BODY: begin
        if (take && rx_last)
          state_d = `BFR_ST_TAIL;
      end
      `BFR_ST_TAIL: begin
        if ((!tx_valid || tx_ready) && tail_q == `BFR_FCS_OCTETS)
          state_d = `BFR_ST_END;
      end
      `BFR_ST_END: begin
        if (!tx_valid || tx_ready)
          state_d = `BFR_ST_IDLE;
      end
      default: state_d = `BFR_ST_IDLE;
    endcase
  end

  // Datapath and output registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= `BFR_ST_IDLE;
      dly_q <= 32'h00000000;
      fill_q <= 3'd0;
      tail_q <= 3'd0;
      fcs_q <= 32'h00000000;
      regen_q <= 1'b0;
      rx_bad_q <= 1'b0;
      orig_bad_q <= 1'b0;
      orig_done_q <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      frame_done <= 1'b0;
      frame_good <= 1'b0;
      frame_drop <= 1'b0;
    end else begin
      state_q <= state_d;
      frame_done <= 1'b0;
      if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      // Original re-check result
      if (orig_valid && orig_last) begin
        orig_done_q <= 1'b1;
        orig_bad_q <= (chk_next != `BFR_CRC_RESIDUE);
      end
      if (take) begin
        if (rx_start) begin
          fill_q <= 3'd1;
          regen_q <= regen;
        end else if (fill_q != `BFR_FCS_OCTETS) begin
          fill_q <= fill_q + 3'd1;
        end
        dly_q <= {rx_data, dly_q[31:8]};
        // Payload octet leaves delay line
        if (gen_adv) begin
          tx_valid <= 1'b1;
          tx_data <= out_octet;
          tx_last <= 1'b0;
        end
        if (rx_last) begin
          tail_q <= 3'd0;
          rx_bad_q <= (rx_next != `BFR_CRC_RESIDUE) ||
                      (!rx_start && fill_q < 3'd3) || rx_start;
          fcs_q <= (gen_adv ? gen_next : gen_crc) ^ `BFR_CRC_XOR;
        end
      end
      // Emit the four check octets
      if (state_q == `BFR_ST_TAIL && (!tx_valid || tx_ready) &&
          tail_q != `BFR_FCS_OCTETS) begin
        tx_valid <= 1'b1;
        tx_data <= regen_q ? fcs_q[7:0] : dly_q[7:0];
        tx_last <= (tail_q == 3'd3);
        fcs_q <= {8'h00, fcs_q[31:8]};
        dly_q <= {8'h00, dly_q[31:8]};
        tail_q <= tail_q + 3'd1;
      end
      // Verdict for the frame
      if (state_q == `BFR_ST_END && (!tx_valid || tx_ready)) begin
        frame_done <= 1'b1;
        // fresh check only if original re-verified
        frame_drop <= rx_bad_q || (regen_q && (!orig_done_q || orig_bad_q));
        frame_good <= !(rx_bad_q || (regen_q && (!orig_done_q || orig_bad_q)));
        orig_done_q <= 1'b0;
        orig_bad_q <= 1'b0;
      end
    end
  end
endmodule // bfr_fcs_relay

// [bench/bfr_relay_checker.sv]
// Purpose: timing checks on the frame check relay ports
// Assumes: one clock, asynchronous active low reset
// Notes: bound to bfr_fcs_relay
`timescale 1ns/10ps
module bfr_relay_checker (
  input wire clock, // Clock
  input wire rst_n, // Reset
  input wire rx_valid, // Rx valid
  input wire rx_last, // Rx last
  input wire rx_ready, // Rx ready
  input wire tx_valid, // Tx valid
  input wire [7:0] tx_data, // Tx octet
  input wire tx_last, // Tx last
  input wire tx_ready, // Tx ready
  input wire frame_done, // Done pulse
  input wire frame_good, // Good flag
  input wire frame_drop // Drop flag
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  done_pulse_a: assert property (frame_done |=> !frame_done)
    else $error("done longer than one cycle");
  verdict_excl_a: assert property (frame_done |-> frame_good != frame_drop)
    else $error("verdict not exclusive");
  verdict_hold_a: assert property ($changed({frame_good, frame_drop}) |-> frame_done)
    else $error("verdict changed without done");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_last}))
    else $error("tx octet dropped while stalled");
  rx_pace_a: assert property (rx_ready |-> !tx_valid || tx_ready)
    else $error("rx ready while output blocked");
  tail_gap_a: assert property (rx_valid && rx_ready && rx_last |=> !rx_ready [*4])
    else $error("rx taken during check tail");
  done_after_a: assert property (tx_valid && tx_ready && tx_last |-> ##[1:3] frame_done)
    else $error("no done after last octet");
  done_idle_a: assert property (frame_done |-> !tx_valid)
    else $error("tx busy at done");
endmodule // bfr_relay_checker
bind bfr_fcs_relay bfr_relay_checker u_bfr_relay_checker (.clock(clock), .rst_n(rst_n),
  .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .frame_done(frame_done),
  .frame_good(frame_good), .frame_drop(frame_drop));

// [bench/bfr_tx_model.sv]
// Purpose: transmit side sink for the relay output
// Assumes: one clock, asynchronous active low reset
// Notes: slow mode halves the take rate
`timescale 1ns/10ps
module bfr_tx_model (
  input wire clock, // Clock
  input wire rst_n, // Reset
  input wire stall, // Slow mode
  output reg tx_ready // Octet taken
);
  // Ready every cycle, or every other one
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
    end
  end
endmodule // bfr_tx_model

// [bench/test_bridge_fcs_regeneration.sv]
// Purpose: self-checking bench of the frame check relay
// Assumes: ten octet frame, four check octets least significant first
// Notes: frames run one at a time, each after the previous verdict
`timescale 1ns/10ps
module test_bridge_fcs_regeneration;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg rx_valid = 1'b0, rx_last = 1'b0, orig_valid = 1'b0, orig_last = 1'b0;
  reg regen = 1'b0, stall = 1'b0;
  reg [7:0] rx_data = 8'h00, orig_data = 8'h00;
  wire rx_ready, tx_valid, tx_last, tx_ready, frame_done, frame_good, frame_drop;
  wire [7:0] tx_data;
  reg [7:0] fr [0:9];
  reg [7:0] got [0:15];
  reg [31:0] crc;
  integer n_got = 0, fails = 0, num_checks = 0, m;
  always #12.5 clock = ~clock;
  bfr_fcs_relay u_bfr_fcs_relay (.clock(clock), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .orig_valid(orig_valid),
    .orig_data(orig_data), .orig_last(orig_last), .regen(regen), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .frame_done(frame_done),
    .frame_good(frame_good), .frame_drop(frame_drop));
  bfr_tx_model u_bfr_tx_model (.clock(clock), .rst_n(rst_n), .stall(stall), .tx_ready(tx_ready));
  // Collect taken output octets
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got[n_got % 16] <= tx_data;
      n_got <= n_got + 1;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("Checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task hang;
    begin
      fails = fails + 1;
      report_and_stop;
    end
  endtask
  // Send frame with optional burst faults, then judge verdict and output
  task run(input r, input [7:0] rf, input [7:0] of, input ed);
    integer i, j, k, base;
    begin
      base = n_got;
      fork
        for (i = 0; i < 10; i = i + 1) begin
          @(posedge clock);
          rx_valid <= 1'b1;
          rx_data <= fr[i] ^ ((i == 2) ? rf : 8'h00);
          rx_last <= (i == 9);
          regen <= r;
          k = 0;
          @(negedge clock);
          while (!rx_ready && k < 100) begin
            @(negedge clock);
            k = k + 1;
          end
          if (k >= 100) hang;
        end
        begin
          for (j = 0; j < 10; j = j + 1) begin
            @(posedge clock);
            orig_valid <= 1'b1;
            orig_data <= fr[j] ^ ((j == 3) ? of : 8'h00);
            orig_last <= (j == 9);
          end
          // Stored copy ends after exactly one frame
          @(posedge clock);
          orig_valid <= 1'b0;
        end
      join
      @(posedge clock);
      rx_valid <= 1'b0;
      k = 0;
      @(negedge clock);
      while (frame_done !== 1'b1 && k < 200) begin
        @(negedge clock);
        k = k + 1;
      end
      if (k >= 200) hang;
      check(frame_drop, ed);
      check(frame_good, !ed);
      if (!ed) begin
        check(n_got - base, 10);
        for (k = 0; k < 10; k = k + 1)
          check(got[(base + k) % 16], fr[k]);
      end
    end
  endtask
  task t_reuse;
    begin
      run(1'b0, 8'h00, 8'h00, 1'b0);
      $display("Test reuse done");
    end
  endtask
  task t_burst;
    begin
      run(1'b0, 8'hff, 8'h00, 1'b1);
      $display("Test burst done");
    end
  endtask
  task t_fresh;
    begin
      run(1'b1, 8'h00, 8'h00, 1'b0);
      $display("Test fresh done");
    end
  endtask
  task t_stored;
    begin
      run(1'b1, 8'h00, 8'h01, 1'b1);
      $display("Test stored done");
    end
  endtask
  task t_stall;
    begin
      stall = 1'b1;
      run(1'b1, 8'h00, 8'h00, 1'b0);
      stall = 1'b0;
      $display("Test stall done");
    end
  endtask
  initial begin
    for (m = 0; m < 6; m = m + 1)
      fr[m] = 8'h30 + m * 8'h17;
    crc = 32'hffffffff;
    for (m = 0; m < 48; m = m + 1)
      crc = ((crc ^ fr[m / 8][m % 8]) & 32'h1) ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
    crc = ~crc;
    {fr[9], fr[8], fr[7], fr[6]} = crc;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reuse;
    t_burst;
    t_fresh;
    t_stored;
    t_stall;
    report_and_stop;
  end
endmodule // test_bridge_fcs_regeneration
